// File: bench/acq_scan_model.sv
`timescale 1ns/1ns
module acq_scan_model
    import spd_pkg::*;
(
    input wire logic clk_i,
    output logic armed_o,
    output logic scan_start_o,
    output logic [31:0] count_o,
    output logic valid_o,
    output spd_pkg::sample_t sample_o
);
    initial begin
        armed_o = 1'b0;
        scan_start_o = 1'b0;
        count_o = 32'h0000_0000;
        valid_o = 1'b0;
        sample_o = '0;
    end

    task automatic set_armed(input logic a);
        armed_o <= a;
    endtask

    // The live count is inverted after the latch, so a design that peeks at it
    // instead of the latched copy is caught.
    task automatic new_scan(input logic [31:0] count);
        count_o <= count;
        scan_start_o <= 1'b1;
        @(posedge clk_i);
        scan_start_o <= 1'b0;
        count_o <= ~count;
    endtask

    // One word per channel per scan, equality only on digital or counter
    // sources, and the status word is read last by software.
    task automatic send(input source_t src, input logic [5:0] chan,
                        input logic [15:0] data);
        valid_o <= 1'b1;
        sample_o <= {src, chan, data};
        @(posedge clk_i);
        valid_o <= 1'b0;
        // An idle link must not look like the word just sent.
        sample_o <= ~sample_o;
    endtask
endmodule

// File: bench/setpoint_detect_output_control_tb.sv
`timescale 1ns/1ns
module setpoint_detect_output_control_tb;
    import spd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hsel = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hrdata, count, rd;
    logic hready, hresp, armed, scan_start, valid;
    sample_t sample;
    logic [15:0] state_word, match_flag, first_square_timer, timer1;
    logic [7:0] port, port_early;
    logic [1:0] tload;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_load0 = 0;
    int n_load1 = 0;
    crit_t crit_tab [14] = '{CRIT_INSIDE, CRIT_INSIDE, CRIT_INSIDE,
        CRIT_OUTSIDE, CRIT_OUTSIDE, CRIT_OUTSIDE, CRIT_GREATER, CRIT_GREATER,
        CRIT_GREATER, CRIT_LESS, CRIT_LESS, CRIT_LESS, CRIT_EQUAL, CRIT_EQUAL};
    logic [15:0] smp_tab [14] = '{16'h0101, 16'h0200, 16'h0100, 16'h0201,
        16'h0200, 16'h00FF, 16'h0101, 16'h0100, 16'h0300, 16'h01FF, 16'h0200,
        16'h0050, 16'h0200, 16'h0100};
    logic met_tab [14] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
        1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [15:0] hys_smp [4] = '{16'h0250, 16'h0150, 16'h0050, 16'h0150};
    logic [7:0] hys_port [4] = '{8'h02, 8'h02, 8'h01, 8'h01};
    logic hys_bit [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

    always #4 clk = ~clk;

    always @(posedge clk) begin
        if (tload[0] === 1'b1) n_load0++;
        if (tload[1] === 1'b1) n_load1++;
    end

    setpoint_detect_output_control u_setpoint_detect_output_control (
        .CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .ACQ_ARMED_I(armed),
        .SCAN_START_I(scan_start), .COUNT_I(count),
        .SAMPLE_VALID_I(valid), .SAMPLE_I(sample),
        .SETPOINT_STATE_WORD_O(state_word),
        .CHANNEL_MATCH_FLAG_O(match_flag), .AUX_DIGITAL_OUT_PORT_O(port),
        .FIRST_SQUARE_TIMER_O(first_square_timer), .SECOND_SQUARE_TIMER_O(timer1),
        .TIMER_LOAD_O(tload));

    acq_scan_model u_acq_scan_model (.clk_i(clk), .armed_o(armed),
        .scan_start_o(scan_start), .count_o(count), .valid_o(valid),
        .sample_o(sample));

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // The slave's wait state is not assumed: both phases wait on hready.
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input string n, input logic [11:0] a,
                          input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(n, rd, e);
    endtask

    function automatic logic [11:0] sp_addr(input int n, input int w);
        return 12'(12'h100 + n * 16 + w * 4);
    endfunction

    function automatic logic [31:0] cfg_word(crit_t c, target_t t,
                                             logic both, logic [5:0] ch);
        return {19'h0, 1'b1, t, both, c, ch};
    endfunction

    task automatic setup(input int n, input logic [31:0] cfg,
        input logic [31:0] bnd, input logic [31:0] pv, input logic [31:0] tv);
        xfer(1'b1, sp_addr(n, 0), cfg);
        xfer(1'b1, sp_addr(n, 1), bnd);
        xfer(1'b1, sp_addr(n, 2), pv);
        xfer(1'b1, sp_addr(n, 3), tv);
    endtask

    // Leaves the port value seen one edge before the evaluation edge.
    task automatic push(input source_t src, input logic [5:0] chan,
                        input logic [15:0] data);
        u_acq_scan_model.send(src, chan, data);
        repeat (249) @(posedge clk);
        #1;
        port_early = port;
        @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk("status reset", 12'h000, 32'h0);
        rd_chk("port reset", 12'h004, 32'h0);
        rd_chk("unmapped", 12'h020, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        xfer(1'b1, 12'h000, 32'hFFFF);
        rd_chk("status ro", 12'h000, 32'h0);
        xfer(1'b1, 12'h004, 32'h5A);
        rd_chk("port rw", 12'h004, 32'h5A);
        xfer(1'b1, 12'h00C, 32'h0000_4321);
        rd_chk("timer1 rw", 12'h00C, 32'h4321);
        check("timer1 pin", timer1, 16'h4321);
        u_acq_scan_model.set_armed(1'b1);
        xfer(1'b1, sp_addr(0, 1), 32'h0200_0100);
        rd_chk("bounds", sp_addr(0, 1), 32'h0200_0100);
        for (int i = 0; i < 14; i++) begin
            xfer(1'b1, sp_addr(0, 0),
                 cfg_word(crit_tab[i], TGT_NONE, 1'b1, 6'd1));
            push((crit_tab[i] == CRIT_EQUAL) ? SRC_DIGITAL : SRC_ANALOG,
                 6'd1, smp_tab[i]);
            check("met", state_word[0], met_tab[i]);
            check("flag", match_flag[0], met_tab[i]);
        end
        check("port idle", port, 8'h5A);
        setup(0, cfg_word(CRIT_INSIDE, TGT_PORT, 1'b1, 6'd1), 32'h0200_0100,
              32'h0F3C_FF70, 32'h0);
        push(SRC_ANALOG, 6'd1, 16'h0150);
        check("port early", port_early, 8'h5A);
        check("port true", port, 8'h70);
        push(SRC_ANALOG, 6'd1, 16'h0300);
        check("port false", port, 8'h7C);
        check("first_square_timer idle", first_square_timer, 16'h0);
        // Samples while disarmed must not reach the outputs.
        u_acq_scan_model.set_armed(1'b0);
        push(SRC_ANALOG, 6'd1, 16'h0150);
        check("unarmed", port, 8'h7C);
        u_acq_scan_model.set_armed(1'b1);
        setup(15, cfg_word(CRIT_GREATER, TGT_FIRST_SQUARE_TIMER, 1'b0, 6'd2),
              32'h0000_0010, 32'hFF55_FFAA, 32'h1111_0064);
        push(SRC_ANALOG, 6'd2, 16'h0020);
        check("first_square_timer", first_square_timer, 16'h0064);
        check("port kept", port, 8'h7C);
        // The load pulse is counted one edge after it is launched.
        rd_chk("status msb", 12'h000, 32'h8000);
        check("first_square_timer loads", n_load0, 1);
        push(SRC_ANALOG, 6'd2, 16'h0005);
        check("true only", first_square_timer, 16'h0064);
        check("msb clear", state_word, 16'h0);
        setup(2, cfg_word(CRIT_HYST, TGT_PORT, 1'b0, 6'd3), 32'h0200_0100,
              32'hFF02_FF01, 32'h0);
        for (int i = 0; i < 4; i++) begin
            push(SRC_ANALOG, 6'd3, hys_smp[i]);
            check("hyst port", port, hys_port[i]);
            check("hyst bit", state_word[2], hys_bit[i]);
        end
        setup(1, cfg_word(CRIT_EQUAL, TGT_TIMER1, 1'b0, 6'd5), 32'h1234_0000,
              32'h0, 32'h0000_BEEF);
        u_acq_scan_model.new_scan(32'hAAAA_1234);
        push(SRC_COUNT_LO, 6'd5, 16'h0000);
        check("count lo", state_word[1], 1'b1);
        check("timer1", timer1, 16'hBEEF);
        rd_chk("count latch", 12'h010, 32'hAAAA_1234);
        u_acq_scan_model.new_scan(32'h1234_0000);
        push(SRC_COUNT_LO, 6'd5, 16'h1234);
        check("count lo miss", state_word[1], 1'b0);
        push(SRC_COUNT_HI, 6'd5, 16'h0000);
        check("count hi", state_word[1], 1'b1);
        @(posedge clk);
        #1;
        check("timer1 loads", n_load1, 2);
        report_and_stop();
    end
endmodule

// File: hw/setpoint_detect_output_control.sv
`timescale 1ns/1ns
`include "spd_cfg.svh"
module setpoint_detect_output_control (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic ACQ_ARMED_I,
    input wire logic SCAN_START_I,
    input wire logic [31:0] COUNT_I,
    input wire logic SAMPLE_VALID_I,
    input wire spd_pkg::sample_t SAMPLE_I,
    output logic [15:0] SETPOINT_STATE_WORD_O,
    output logic [15:0] CHANNEL_MATCH_FLAG_O,
    output logic [7:0] AUX_DIGITAL_OUT_PORT_O,
    output logic [15:0] FIRST_SQUARE_TIMER_O,
    output logic [15:0] SECOND_SQUARE_TIMER_O,
    output logic [1:0] TIMER_LOAD_O
);
    import spd_pkg::*;

    localparam logic [7:0] DELAY = 8'(`SPD_EVAL_DELAY_CYC);
    localparam int NS = `SPD_NUM_SP;
    localparam int NSL = `SPD_NUM_SLOTS;

    // Met state for any criterion; hysteresis keeps prev inside the window.
    function automatic logic crit_met(crit_t c, logic [15:0] x,
                                      bounds_t b, logic prev);
        case (c)
            CRIT_INSIDE: crit_met = (x < b.upper) && (x > b.lower);
            CRIT_OUTSIDE: crit_met = (x > b.upper) || (x < b.lower);
            CRIT_GREATER: crit_met = x > b.lower;
            CRIT_LESS: crit_met = x < b.upper;
            CRIT_EQUAL: crit_met = x == b.upper;
            CRIT_HYST: begin
                if (x > b.upper) begin
                    crit_met = 1'b1;
                end else if (x < b.lower) begin
                    crit_met = 1'b0;
                end else begin
                    crit_met = prev;
                end
            end
            default: crit_met = 1'b0;
        endcase
    endfunction

    // Bus slave: one wait state so read data always leaves a flip-flop.
    logic take;
    logic pend_reg;
    logic pwrite_reg;
    logic [11:0] paddr_reg;
    logic ready_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_word;
    logic sp_acc;
    logic [3:0] sp_idx;
    logic [1:0] sp_word;

    assign take = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign sp_acc = paddr_reg[11:8] == `SPD_SP_REGION;
    assign sp_idx = paddr_reg[7:4];
    assign sp_word = paddr_reg[3:2];

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            pend_reg <= 1'b0;
            pwrite_reg <= 1'b0;
            paddr_reg <= 12'h000;
            ready_reg <= 1'b1;
        end else begin
            pend_reg <= take;
            ready_reg <= !take;
            if (take) begin
                pwrite_reg <= HWRITE_I;
                paddr_reg <= HADDR_I[11:0];
            end
        end
    end

    // Setpoint storage.
    sp_cfg_t cfg_mem [NS];
    bounds_t bnd_mem [NS];
    port_vals_t pv_mem [NS];
    timer_vals_t tv_mem [NS];
    logic sp_wr;

    assign sp_wr = pend_reg && pwrite_reg && sp_acc;

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < NS; i++) begin
                cfg_mem[i] <= '0;
                bnd_mem[i] <= '0;
                pv_mem[i] <= '0;
                tv_mem[i] <= '0;
            end
        end else if (sp_wr) begin
            case (sp_word)
                `SPD_W_CFG: cfg_mem[sp_idx] <= HWDATA_I[`SPD_CFG_BITS-1:0];
                `SPD_W_BOUNDS: bnd_mem[sp_idx] <= HWDATA_I;
                `SPD_W_PORT: pv_mem[sp_idx] <= HWDATA_I;
                default: tv_mem[sp_idx] <= HWDATA_I;
            endcase
        end
    end

    // Counter latched once per scan.
    logic [31:0] count_reg;

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            count_reg <= 32'h00000000;
        end else if (SCAN_START_I) begin
            count_reg <= COUNT_I;
        end
    end

    // Pipeline slots model the converter latency; a sample that finds
    // every slot busy is dropped, which the scan rate limit rules out.
    logic [NSL-1:0] slot_busy_reg;
    logic [7:0] slot_cnt_reg [NSL];
    sample_t slot_smp_reg [NSL];
    logic [1:0] free_idx;
    logic free_any;
    logic [1:0] fire_idx;
    logic eval_valid;
    logic samp_take;
    sample_t samp_res;

    always_comb begin
        free_idx = 2'h0;
        free_any = 1'b0;
        fire_idx = 2'h0;
        eval_valid = 1'b0;
        for (int i = NSL - 1; i >= 0; i--) begin
            if (!slot_busy_reg[i]) begin
                free_idx = 2'(i);
                free_any = 1'b1;
            end
            if (slot_busy_reg[i] && slot_cnt_reg[i] == 8'h01) begin
                fire_idx = 2'(i);
                eval_valid = 1'b1;
            end
        end
    end

    always_comb begin
        samp_res = SAMPLE_I;
        if (SAMPLE_I.src == SRC_COUNT_LO) begin
            samp_res.data = count_reg[15:0];
        end else if (SAMPLE_I.src == SRC_COUNT_HI) begin
            samp_res.data = count_reg[31:16];
        end
    end

    assign samp_take = SAMPLE_VALID_I && ACQ_ARMED_I && free_any;

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I || !ACQ_ARMED_I) begin
            slot_busy_reg <= '0;
            for (int i = 0; i < NSL; i++) begin
                slot_cnt_reg[i] <= 8'h00;
                slot_smp_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NSL; i++) begin
                if (samp_take && free_idx == 2'(i)) begin
                    slot_busy_reg[i] <= 1'b1;
                    slot_cnt_reg[i] <= DELAY;
                    slot_smp_reg[i] <= samp_res;
                end else if (slot_busy_reg[i]) begin
                    slot_cnt_reg[i] <= slot_cnt_reg[i] - 8'h01;
                    if (slot_cnt_reg[i] == 8'h01) begin
                        slot_busy_reg[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // Evaluation: the channel's own sample judges its setpoint once per scan.
    sample_t eval_smp;
    logic [NS-1:0] hit;
    logic [NS-1:0] met_reg;
    logic [NS-1:0] met_next;

    assign eval_smp = slot_smp_reg[fire_idx];

    for (genvar n = 0; n < NS; n++) begin : g_sp
        assign hit[n] = eval_valid && cfg_mem[n].enable &&
                        cfg_mem[n].chan == eval_smp.chan;
        assign met_next[n] = crit_met(cfg_mem[n].crit, eval_smp.data,
                                      bnd_mem[n], met_reg[n]);
        always_ff @(posedge CLOCK_I) begin
            if (!RST_N_I) begin
                met_reg[n] <= 1'b0;
            end else if (hit[n]) begin
                met_reg[n] <= met_next[n];
            end
        end
    end

    // Action of the lowest hit setpoint; one per channel makes this unique.
    logic [3:0] sel_idx;
    logic sel_valid;
    logic sel_met;
    logic act_apply;
    logic act_second;
    sp_cfg_t sel_cfg;
    bounds_t sel_bnd;
    logic [7:0] act_data;
    logic [7:0] act_mask;
    logic [15:0] act_timer;

    always_comb begin
        sel_idx = 4'h0;
        sel_valid = 1'b0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sel_idx = 4'(i);
                sel_valid = 1'b1;
            end
        end
    end

    assign sel_cfg = cfg_mem[sel_idx];
    assign sel_bnd = bnd_mem[sel_idx];
    assign sel_met = met_next[sel_idx];

    always_comb begin
        act_apply = 1'b0;
        act_second = 1'b0;
        if (sel_valid && sel_cfg.crit == CRIT_HYST) begin
            act_apply = eval_smp.data > sel_bnd.upper ||
                        eval_smp.data < sel_bnd.lower;
            act_second = eval_smp.data > sel_bnd.upper;
        end else if (sel_valid) begin
            act_apply = sel_met || sel_cfg.both_edges;
            act_second = !sel_met;
        end
        act_data = act_second ? pv_mem[sel_idx].data2 : pv_mem[sel_idx].data1;
        act_mask = act_second ? pv_mem[sel_idx].mask2 : pv_mem[sel_idx].mask1;
        act_timer = act_second ? tv_mem[sel_idx].val2 : tv_mem[sel_idx].val1;
    end

    logic port_upd;
    logic [1:0] tmr_upd;
    logic [7:0] port_reg;
    logic [15:0] tmr0_reg;
    logic [15:0] tmr1_reg;
    logic [1:0] tload_reg;
    logic sw_wr;

    assign port_upd = act_apply && sel_cfg.target == TGT_PORT;
    assign tmr_upd[0] = act_apply && sel_cfg.target == TGT_FIRST_SQUARE_TIMER;
    assign tmr_upd[1] = act_apply && sel_cfg.target == TGT_TIMER1;
    assign sw_wr = pend_reg && pwrite_reg;

    // A setpoint update wins over a software write in the same cycle.
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            port_reg <= `SPD_PORT_RST;
        end else if (port_upd) begin
            port_reg <= (port_reg & ~act_mask) | (act_data & act_mask);
        end else if (sw_wr && paddr_reg == `SPD_OFS_PORT) begin
            port_reg <= HWDATA_I[7:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            tmr0_reg <= `SPD_TIMER_RST;
            tmr1_reg <= `SPD_TIMER_RST;
            tload_reg <= 2'h0;
        end else begin
            tload_reg <= tmr_upd;
            if (tmr_upd[0]) begin
                tmr0_reg <= act_timer;
            end else if (sw_wr && paddr_reg == `SPD_OFS_FIRST_SQUARE_TIMER) begin
                tmr0_reg <= HWDATA_I[15:0];
            end
            if (tmr_upd[1]) begin
                tmr1_reg <= act_timer;
            end else if (sw_wr && paddr_reg == `SPD_OFS_TIMER1) begin
                tmr1_reg <= HWDATA_I[15:0];
            end
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        if (sp_acc) begin
            case (sp_word)
                `SPD_W_CFG: rd_word = 32'(cfg_mem[sp_idx]);
                `SPD_W_BOUNDS: rd_word = bnd_mem[sp_idx];
                `SPD_W_PORT: rd_word = pv_mem[sp_idx];
                default: rd_word = tv_mem[sp_idx];
            endcase
        end else begin
            case (paddr_reg)
                `SPD_OFS_STATUS: rd_word = {16'h0000, met_reg};
                `SPD_OFS_PORT: rd_word = {24'h000000, port_reg};
                `SPD_OFS_FIRST_SQUARE_TIMER: rd_word = {16'h0000, tmr0_reg};
                `SPD_OFS_TIMER1: rd_word = {16'h0000, tmr1_reg};
                `SPD_OFS_COUNT: rd_word = count_reg;
                default: rd_word = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            rdata_reg <= 32'h00000000;
        end else if (pend_reg && !pwrite_reg) begin
            rdata_reg <= rd_word;
        end
    end

    assign HRDATA_O = rdata_reg;
    assign HREADYOUT_O = ready_reg;
    assign HRESP_O = 1'b0;
    assign SETPOINT_STATE_WORD_O = met_reg;
    assign CHANNEL_MATCH_FLAG_O = met_reg;
    assign AUX_DIGITAL_OUT_PORT_O = port_reg;
    assign FIRST_SQUARE_TIMER_O = tmr0_reg;
    assign SECOND_SQUARE_TIMER_O = tmr1_reg;
    assign TIMER_LOAD_O = tload_reg;

    default clocking @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_eval_delay: assert property (eval_valid |-> $past(samp_take, 250))
        else $error("evaluation not 250 cycles after sample");
    a_port_masked: assert property (port_upd |=> port_reg ==
        (($past(port_reg) & ~$past(act_mask)) |
         ($past(act_data) & $past(act_mask))))
        else $error("masked port update wrong");
    a_inside_crit: assert property (sel_valid &&
        sel_cfg.crit == CRIT_INSIDE |=> met_reg[$past(sel_idx)] ==
        ($past(eval_smp.data) < $past(sel_bnd.upper) &&
         $past(eval_smp.data) > $past(sel_bnd.lower)))
        else $error("inside window status wrong");
    a_equal_crit: assert property (sel_valid && sel_cfg.crit == CRIT_EQUAL
        |=> met_reg[$past(sel_idx)] ==
        ($past(eval_smp.data) == $past(sel_bnd.upper)))
        else $error("equality status wrong");
    a_hyst_hold: assert property (sel_valid && sel_cfg.crit == CRIT_HYST &&
        eval_smp.data <= sel_bnd.upper && eval_smp.data >= sel_bnd.lower
        |=> $stable(met_reg) && $stable(port_reg) && tload_reg == 2'h0)
        else $error("hysteresis changed inside window");
    a_true_only: assert property (sel_valid && sel_cfg.crit != CRIT_HYST &&
        !sel_cfg.both_edges && !sel_met |=> $stable(port_reg) &&
        tload_reg == 2'h0)
        else $error("false condition acted in true-only mode");
    a_target_none: assert property (sel_valid &&
        sel_cfg.target == TGT_NONE && !sw_wr
        |=> $stable(port_reg) && tload_reg == 2'h0)
        else $error("update reached an unselected target");
    a_unarmed_idle: assert property (!ACQ_ARMED_I |=> !eval_valid ##1
        !eval_valid)
        else $error("evaluation while not armed");
    a_timer_load: assert property (tmr_upd[0] |=> tload_reg[0] &&
        tmr0_reg == $past(act_timer))
        else $error("timer load wrong");
    a_bus_wait: assert property (take |=> !HREADYOUT_O ##1 HREADYOUT_O)
        else $error("bus wait state wrong");

    c_port_update: cover property (port_upd);
    c_hyst_high: cover property (sel_valid && sel_cfg.crit == CRIT_HYST &&
        act_second);
    c_timer1_load: cover property (tmr_upd[1]);
    c_bus_read: cover property (pend_reg && !pwrite_reg);
endmodule

// File: hw/spd_cfg.svh
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH

`define SPD_NUM_SP 16
`define SPD_NUM_SLOTS 4
`define SPD_CLK_PERIOD_NS 8
`define SPD_EVAL_DELAY_NS 2000
`define SPD_EVAL_DELAY_CYC \
    ((`SPD_EVAL_DELAY_NS + `SPD_CLK_PERIOD_NS - 1) / `SPD_CLK_PERIOD_NS)

`define SPD_OFS_STATUS 12'h000
`define SPD_OFS_PORT 12'h004
`define SPD_OFS_FIRST_SQUARE_TIMER 12'h008
`define SPD_OFS_TIMER1 12'h00C
`define SPD_OFS_COUNT 12'h010
`define SPD_SP_REGION 4'h1
`define SPD_W_CFG 2'h0
`define SPD_W_BOUNDS 2'h1
`define SPD_W_PORT 2'h2
`define SPD_W_TIMER 2'h3
`define SPD_CFG_BITS 13

`define SPD_PORT_RST 8'h00
`define SPD_TIMER_RST 16'h0000

`endif

// File: hw/spd_pkg.sv
package spd_pkg;
    typedef enum logic [2:0] {
        CRIT_INSIDE,
        CRIT_OUTSIDE,
        CRIT_GREATER,
        CRIT_LESS,
        CRIT_EQUAL,
        CRIT_HYST
    } crit_t;
    typedef enum logic [1:0] {TGT_NONE, TGT_PORT, TGT_FIRST_SQUARE_TIMER, TGT_TIMER1}
        target_t;
    typedef enum logic [1:0] {SRC_ANALOG, SRC_DIGITAL, SRC_COUNT_LO,
        SRC_COUNT_HI} source_t;
    typedef struct packed {
        source_t src;
        logic [5:0] chan;
        logic [15:0] data;
    } sample_t;
    typedef struct packed {
        logic enable;
        target_t target;
        logic both_edges;
        crit_t crit;
        logic [5:0] chan;
    } sp_cfg_t;
    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
    } bounds_t;
    typedef struct packed {
        logic [7:0] mask2;
        logic [7:0] data2;
        logic [7:0] mask1;
        logic [7:0] data1;
    } port_vals_t;
    typedef struct packed {
        logic [15:0] val2;
        logic [15:0] val1;
    } timer_vals_t;
endpackage
